// ===== ocm_output_latency_monitor.sv
// Output latency, frame skew and clock monitor configuration bank with its applied values.
//
// Functional notes
// - Coarse phase delays outputs when pin control off.
// - Coarse phase is two's complement, -128..+127.
// - Coarse phase change ramps gradually, up to 20s.
// - Feedback divider 000 freezes coarse phase.
// - Fine latency is 15 bits across two registers.
// - Commit low holds previously captured fine latency.
// - Commit high takes fine latency from registers.
// - Fine latency high register resets to 0x80.
// - Global enable gates per-input offset detection.
// - Two-bit code selects offset detection threshold.
// - Input valid for selected time clears alarm.
// - Phase slips retrigger lock one-shot, halving intervals.
// - Monitor configuration register resets to 0x2c.
// - Routing register: six enables, resets 0x3c.
// - Skew and coarse registers reset to zero.
// - Frame skew delays frame sync in output periods.
// - Skew commit low holds previously captured skew.
// - Pin select low ignores increment/decrement inputs.
// - Interrupt routing overrides alarm; none tristates.
`default_nettype none
module ocm_output_latency_monitor #(
  parameter int CLEAR_DELAY0 = ocm_pkg::CLEAR_DELAY0_CYC,
  parameter int CLEAR_DELAY1 = ocm_pkg::CLEAR_DELAY1_CYC,
  parameter int CLEAR_DELAY2 = ocm_pkg::CLEAR_DELAY2_CYC,
  parameter int CLEAR_DELAY3 = ocm_pkg::CLEAR_DELAY3_CYC,
  parameter int ONESHOT_BASE = ocm_pkg::ONESHOT_BASE_CYC,
  parameter int RAMP_STEP    = ocm_pkg::RAMP_STEP_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  input  wire logic        frameDelayCommit,
  input  wire logic        frameDelayBit16,
  input  wire logic        phaseStepPinSelect,
  input  wire logic [2:0]  feedbackHighSpeedDivider,
  input  wire logic        phaseIncPin,
  input  wire logic        phaseDecPin,
  input  wire logic [3:0]  offsetDetectInputEnable,
  input  wire logic [3:0]  offsetRaw,
  input  wire logic [3:0]  inputValid,
  input  wire logic        phaseSlip,
  input  wire logic        interruptStatus,
  output logic      [16:0] frameSyncDelay,
  output logic      [14:0] fineLatencyValue,
  output logic      [7:0]  coarsePhaseApplied,
  output logic      [3:0]  offsetDetectEnable,
  output logic      [1:0]  offsetDetectThreshold,
  output logic      [3:0]  frequencyOffsetAlarm,
  output logic      [3:0]  inputAlarm,
  output logic             lockLoss,
  output logic             alarmPinOut,
  output logic             alarmPinOe,
  output logic      [2:0]  faultPinOut,
  output logic      [2:0]  faultPinOe,
  output logic             lockLossPinOut,
  output logic             lockLossPinOe
);

  // Stored register bytes, one flop bank per mapped address.
  logic [7:0]  skewMid_q;
  logic [7:0]  skewLow_q;
  logic [7:0]  coarse_q;
  logic [7:0]  fineHigh_q;
  logic [7:0]  fineLow_q;
  logic [7:0]  monitor_q;
  logic [7:0]  routing_q;
  logic [7:0]  rdData_d;
  // Synchroniser, edge-history and slow-timer state.
  logic        incSync0_q;
  logic        incSync1_q;
  logic        incPrev_q;
  logic        decSync0_q;
  logic        decSync1_q;
  logic        decPrev_q;
  logic        incRise;
  logic        decRise;
  logic [21:0] rampCnt_q;
  logic [22:0] lockCnt_q;
  logic [22:0] lockLoad;
  logic [29:0] clearLimit;
  logic        anyAlarm;

  // Register writes; unmapped addresses are ignored.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      skewMid_q  <= ocm_pkg::RST_SKEW_MID;
      skewLow_q  <= ocm_pkg::RST_SKEW_LOW;
      coarse_q   <= ocm_pkg::RST_COARSE;
      fineHigh_q <= ocm_pkg::RST_FINE_HIGH;
      fineLow_q  <= ocm_pkg::RST_FINE_LOW;
      monitor_q  <= ocm_pkg::RST_MONITOR;
      routing_q  <= ocm_pkg::RST_ROUTING;
    end else if (regWrEn) begin
      // Bytes are stored as written, routing masked to its six bits; applied skew and fine latency are taken elsewhere under commit.
      // A read in the same cycle returns the byte from before this write.
      case (regAddr)
        ocm_pkg::ADDR_SKEW_MID:  skewMid_q  <= regWrData;
        ocm_pkg::ADDR_SKEW_LOW:  skewLow_q  <= regWrData;
        ocm_pkg::ADDR_COARSE:    coarse_q   <= regWrData;
        ocm_pkg::ADDR_FINE_HIGH: fineHigh_q <= regWrData;
        ocm_pkg::ADDR_FINE_LOW:  fineLow_q  <= regWrData;
        ocm_pkg::ADDR_MONITOR:   monitor_q  <= regWrData;
        ocm_pkg::ADDR_ROUTING:   routing_q  <= regWrData & ocm_pkg::ROUTING_WRITE_MASK;
        default:                 ;
      endcase
    end
  end

  // Read mux; an unmapped address reads as zero.
  // Decoding the raw address keeps the read latency at one cycle.
  always_comb begin
    case (regAddr)
      ocm_pkg::ADDR_SKEW_MID:  rdData_d = skewMid_q;
      ocm_pkg::ADDR_SKEW_LOW:  rdData_d = skewLow_q;
      ocm_pkg::ADDR_COARSE:    rdData_d = coarse_q;
      ocm_pkg::ADDR_FINE_HIGH: rdData_d = fineHigh_q;
      ocm_pkg::ADDR_FINE_LOW:  rdData_d = fineLow_q;
      ocm_pkg::ADDR_MONITOR:   rdData_d = monitor_q;
      ocm_pkg::ADDR_ROUTING:   rdData_d = routing_q;
      default:                 rdData_d = ocm_pkg::READ_UNMAPPED;
    endcase
  end

  // Read data is captured on the read strobe and held until the next read.
  // Holding the byte lets a slow host fetch it at leisure after the strobe.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      regRdData <= ocm_pkg::READ_UNMAPPED;
    end else if (regRdEn) begin
      regRdData <= rdData_d;
    end
  end

  // Applied frame skew follows the bytes only while committed, so half-written values never leak.
  // Bit 16 lives outside this bank, so the host must keep it steady while committed.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      frameSyncDelay <= '0;
    end else if (frameDelayCommit) begin
      frameSyncDelay <= {frameDelayBit16, skewMid_q, skewLow_q};
    end
  end

  // Applied fine latency, captured from both registers while the commit bit is set.
  // Reset leaves the commit bit set, so the applied value tracks the zero bytes at once.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      fineLatencyValue <= '0;
    end else if (fineHigh_q[ocm_pkg::FINE_COMMIT_BIT]) begin
      fineLatencyValue <= {fineHigh_q[ocm_pkg::FINE_HIGH_MSB:0], fineLow_q};
    end
    // the host brackets its writes with the commit bit.
  end

  // Two-flop synchronisers for the asynchronous step pins, plus an edge history flop.
  // Only the second flop feeds logic, since the first may go metastable.
  // Pulses shorter than one clock period may be missed; the pins suit slow controls.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      incSync0_q <= 1'b0;
      incSync1_q <= 1'b0;
      incPrev_q  <= 1'b0;
      decSync0_q <= 1'b0;
      decSync1_q <= 1'b0;
      decPrev_q  <= 1'b0;
    end else begin
      incSync0_q <= phaseIncPin;
      incSync1_q <= incSync0_q;
      incPrev_q  <= incSync1_q;
      decSync0_q <= phaseDecPin;
      decSync1_q <= decSync0_q;
      decPrev_q  <= decSync1_q;
    end
  end

  // The history flop turns each synced rising edge into a one-cycle step request.
  assign incRise = incSync1_q & ~incPrev_q;
  assign decRise = decSync1_q & ~decPrev_q;

  // Coarse phase: slow ramp toward the register, or pin stepping when pins are selected.
  // The ramp keeps output clocks free of phase hits at the cost of a long settle time.
  // The ramp counter restarts in every other mode, so a later ramp gets a full interval.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      coarsePhaseApplied <= ocm_pkg::RST_COARSE;
      rampCnt_q          <= '0;
    end else if (feedbackHighSpeedDivider == ocm_pkg::FEEDBACK_DIV_OFF) begin
      rampCnt_q <= '0;
    end else if (phaseStepPinSelect) begin
      // Pin mode leaves the register alone; only synced edges move the phase.
      rampCnt_q <= '0;
      // Both pins in one cycle cancel; steps saturate at the signed limits.
      if (incRise && !decRise && $signed(coarsePhaseApplied) != 8'sh7f) begin
        coarsePhaseApplied <= coarsePhaseApplied + 8'h01;
      end else if (decRise && !incRise && $signed(coarsePhaseApplied) != -8'sh80) begin
        coarsePhaseApplied <= coarsePhaseApplied - 8'h01;
      end
    end else if (coarsePhaseApplied == coarse_q) begin
      rampCnt_q <= '0;
    end else if (rampCnt_q >= 22'(RAMP_STEP - 1)) begin
      rampCnt_q <= '0;
      if ($signed(coarse_q) > $signed(coarsePhaseApplied)) begin
        coarsePhaseApplied <= coarsePhaseApplied + 8'h01;
      end else begin
        coarsePhaseApplied <= coarsePhaseApplied - 8'h01;
      end
    end else begin
      rampCnt_q <= rampCnt_q + 22'h000001;
    end
  end

  // Offset detection enables and threshold, registered for the monitor.
  // The alarm uses last cycle's enables, so a change shows one cycle later.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      offsetDetectEnable    <= '0;
      offsetDetectThreshold <= ocm_pkg::RST_MONITOR[ocm_pkg::THRESHOLD_LSB +: 2];
      frequencyOffsetAlarm  <= '0;
    end else begin
      offsetDetectEnable    <= {4{monitor_q[ocm_pkg::OFFSET_EN_BIT]}} & offsetDetectInputEnable;
      offsetDetectThreshold <= monitor_q[ocm_pkg::THRESHOLD_LSB +: 2];
      frequencyOffsetAlarm  <= offsetRaw & offsetDetectEnable;
    end
  end

  // Clear delay limit for the selected code.
  // Limits are cycle counts, so they hold only at the nominal reference clock rate.
  always_comb begin
    case (monitor_q[ocm_pkg::CLEAR_DELAY_LSB +: 2])
      2'h0:    clearLimit = 30'(CLEAR_DELAY0);
      2'h1:    clearLimit = 30'(CLEAR_DELAY1);
      2'h2:    clearLimit = 30'(CLEAR_DELAY2);
      default: clearLimit = 30'(CLEAR_DELAY3);
    endcase
  end

  // One validation timer per input; any invalid cycle restarts the wait.
  // A code change mid-count compares the running count with the new limit.
  for (genvar i = 0; i < 4; i++) begin : g_valid
    logic [29:0] validCnt_q;
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        inputAlarm[i] <= 1'b1;
        validCnt_q    <= '0;
      end else if (!inputValid[i]) begin
        inputAlarm[i] <= 1'b1;
        validCnt_q    <= '0;
      end else if (inputAlarm[i]) begin
        if (validCnt_q >= clearLimit - 30'h1) begin
          inputAlarm[i] <= 1'b0;
          validCnt_q    <= '0;
        end else begin
          validCnt_q <= validCnt_q + 30'h1;
        end
      end
    end
  end

  // Lock one-shot length: base interval shifted right by the code.
  // Shifting halves exactly for the default base, so even the shortest interval lands on nominal.
  assign lockLoad = 23'(ONESHOT_BASE) >> monitor_q[ocm_pkg::ONESHOT_LSB +: 3];

  // Each phase slip reloads the one-shot; lock is lost while it runs.
  // A slip inside a running interval restarts it; lock returns after a quiet interval.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lockCnt_q <= '0;
      lockLoss  <= 1'b0;
    end else if (phaseSlip) begin
      lockCnt_q <= lockLoad;
      lockLoss  <= 1'b1;
    end else if (lockCnt_q > 23'h1) begin
      // Count down quietly until the interval runs out.
      lockCnt_q <= lockCnt_q - 23'h1;
    end else begin
      lockCnt_q <= '0;
      lockLoss  <= 1'b0;
    end
  end

  // Any input in alarm raises the shared alarm status.
  assign anyAlarm = |inputAlarm;

  // Status pin routing; a disabled pin has its enable low and drives zero.
  // Driving zero keeps internal nets defined; the low enable tristates the pad.
  // Fault pins cover inputs one to three; the fourth input has no pin of its own.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      alarmPinOut    <= 1'b0;
      alarmPinOe     <= 1'b0;
      faultPinOut    <= '0;
      faultPinOe     <= '0;
      lockLossPinOut <= 1'b0;
      lockLossPinOe  <= 1'b0;
    end else begin
      if (routing_q[ocm_pkg::ROUTE_INT_BIT]) begin
        alarmPinOut <= interruptStatus;
        alarmPinOe  <= 1'b1;
      end else if (routing_q[ocm_pkg::ROUTE_ALARM_BIT]) begin
        alarmPinOut <= anyAlarm;
        alarmPinOe  <= 1'b1;
      end else begin
        alarmPinOut <= 1'b0;
        alarmPinOe  <= 1'b0;
      end
      faultPinOe     <= routing_q[ocm_pkg::ROUTE_FAULT_LSB +: 3];
      faultPinOut    <= inputAlarm[2:0] & routing_q[ocm_pkg::ROUTE_FAULT_LSB +: 3];
      lockLossPinOe  <= routing_q[ocm_pkg::ROUTE_LOCK_BIT];
      lockLossPinOut <= lockLoss & routing_q[ocm_pkg::ROUTE_LOCK_BIT];
    end
  end

endmodule
`default_nettype wire

// ===== ocm_pkg.sv
// Register map, reset values, field positions and timing counts of the latency and monitor bank.
`default_nettype none
package ocm_pkg;
  // Register offsets on the serial management register port.
  localparam logic [7:0] ADDR_SKEW_MID   = 8'h0e;
  localparam logic [7:0] ADDR_SKEW_LOW   = 8'h0f;
  localparam logic [7:0] ADDR_COARSE     = 8'h10;
  localparam logic [7:0] ADDR_FINE_HIGH  = 8'h11;
  localparam logic [7:0] ADDR_FINE_LOW   = 8'h12;
  localparam logic [7:0] ADDR_MONITOR    = 8'h13;
  localparam logic [7:0] ADDR_ROUTING    = 8'h14;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;

  // Reset values.
  localparam logic [7:0] RST_SKEW_MID    = 8'h00;
  localparam logic [7:0] RST_SKEW_LOW    = 8'h00;
  localparam logic [7:0] RST_COARSE      = 8'h00;
  localparam logic [7:0] RST_FINE_HIGH   = 8'h80;
  localparam logic [7:0] RST_FINE_LOW    = 8'h00;
  localparam logic [7:0] RST_MONITOR     = 8'h2c;
  localparam logic [7:0] RST_ROUTING     = 8'h3c;

  // Field positions.
  localparam int FINE_COMMIT_BIT   = 7;
  localparam int FINE_HIGH_MSB     = 6;
  localparam int OFFSET_EN_BIT     = 7;
  localparam int THRESHOLD_LSB     = 5;
  localparam int CLEAR_DELAY_LSB   = 3;
  localparam int ONESHOT_LSB       = 0;
  localparam int ROUTE_ALARM_BIT   = 5;
  localparam int ROUTE_FAULT_LSB   = 2;
  localparam int ROUTE_LOCK_BIT    = 1;
  localparam int ROUTE_INT_BIT     = 0;
  localparam logic [7:0] ROUTING_WRITE_MASK = 8'h3f;
  localparam logic [2:0] FEEDBACK_DIV_OFF   = 3'h0;

  // Timing: reference clock period and derived cycles per unit.
  localparam int CLK_PERIOD_NS  = 25;
  localparam int CYC_PER_US     = 1000 / CLK_PERIOD_NS;
  localparam int CYC_PER_MS     = 1000000 / CLK_PERIOD_NS;

  // Alarm clear delays, one per code.
  localparam int CLEAR_DELAY0_MS = 2;
  localparam int CLEAR_DELAY1_MS = 100;
  localparam int CLEAR_DELAY2_MS = 200;
  localparam int CLEAR_DELAY3_MS = 13000;
  localparam int CLEAR_DELAY0_CYC = CLEAR_DELAY0_MS * CYC_PER_MS;
  localparam int CLEAR_DELAY1_CYC = CLEAR_DELAY1_MS * CYC_PER_MS;
  localparam int CLEAR_DELAY2_CYC = CLEAR_DELAY2_MS * CYC_PER_MS;
  localparam int CLEAR_DELAY3_CYC = CLEAR_DELAY3_MS * CYC_PER_MS;

  // Lock one-shot interval at code 000; each code step halves it.
  localparam int ONESHOT_BASE_US  = 106000;
  localparam int ONESHOT_BASE_CYC = ONESHOT_BASE_US * CYC_PER_US;

  // Coarse phase ramp: a full 256-step swing takes at most 20 seconds.
  localparam int RAMP_TOTAL_MS   = 20000;
  localparam int RAMP_STEPS      = 256;
  localparam int RAMP_STEP_CYC   = RAMP_TOTAL_MS * CYC_PER_MS / RAMP_STEPS;
endpackage
`default_nettype wire

// ===== ocm_output_latency_monitor_asserts.sv
// Concurrent checks on the ports of the latency and monitor bank.
`default_nettype none
module ocm_output_latency_monitor_asserts (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic [7:0]  regRdData,
  input wire logic        frameDelayCommit,
  input wire logic        frameDelayBit16,
  input wire logic [2:0]  feedbackHighSpeedDivider,
  input wire logic [3:0]  offsetDetectInputEnable,
  input wire logic [3:0]  inputValid,
  input wire logic        phaseSlip,
  input wire logic        interruptStatus,
  input wire logic [16:0] frameSyncDelay,
  input wire logic [14:0] fineLatencyValue,
  input wire logic [7:0]  coarsePhaseApplied,
  input wire logic [3:0]  offsetDetectEnable,
  input wire logic [1:0]  offsetDetectThreshold,
  input wire logic [3:0]  inputAlarm,
  input wire logic        lockLoss,
  input wire logic        alarmPinOut,
  input wire logic        alarmPinOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] shQ [7];
  logic [7:0] off;
  logic [7:0] rdExp;
  // Offset into the shadow; addresses below the bank wrap high and count as unmapped.
  assign off = regAddr - 8'h0e;
  assign rdExp = (off < 8'h07) ? (shQ[off[2:0]] & ((off == 8'h06) ? 8'h3f : 8'hff)) : 8'h00;
  // Shadow of the bank, written on the same edge as the design's registers.
  always_ff @(posedge ref_clk) begin
    if (!rstn) shQ <= '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h2c, 8'h3c};
    else if (regWrEn && off < 8'h07) shQ[off[2:0]] <= regWrData;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  rd_data_a: assert property (regRdEn && !regWrEn |=> regRdData == $past(rdExp))
    else $error("read data differs from register contents");
  rd_hold_a: assert property (!regRdEn |=> $stable(regRdData))
    else $error("read data changed without a read");
  fine_hold_a: assert property (!shQ[3][7] |=> $stable(fineLatencyValue))
    else $error("fine latency moved while commit low");
  fine_copy_a: assert property (shQ[3][7] |=> fineLatencyValue == $past({shQ[3][6:0], shQ[4]}))
    else $error("fine latency not taken from registers");
  skew_hold_a: assert property (!frameDelayCommit |=> $stable(frameSyncDelay))
    else $error("frame skew moved while commit low");
  skew_copy_a: assert property (frameDelayCommit |=>
    frameSyncDelay == $past({frameDelayBit16, shQ[0], shQ[1]}))
    else $error("frame skew not taken from registers");
  div_freeze_a: assert property (feedbackHighSpeedDivider == 3'h0 |=> $stable(coarsePhaseApplied))
    else $error("coarse phase moved with divider off");
  oneshot_start_a: assert property (phaseSlip |=> lockLoss)
    else $error("phase slip did not start lock one-shot");
  alarm_set_a: assert property (inputValid != 4'hf |=> (inputAlarm | $past(inputValid)) == 4'hf)
    else $error("invalid input did not raise alarm");
  offset_cfg_a: assert property (1'b1 |=> offsetDetectThreshold == $past(shQ[5][6:5]) &&
    offsetDetectEnable == ($past(shQ[5][7]) ? $past(offsetDetectInputEnable) : 4'h0))
    else $error("offset detect enable or threshold wrong");
  pin_int_a: assert property (shQ[6][0] |=> alarmPinOe && alarmPinOut == $past(interruptStatus))
    else $error("interrupt not shown on shared pin");
  cover property (phaseSlip);
  cover property (shQ[6][0] && interruptStatus);
  cover property (regRdEn && off >= 8'h07);
endmodule
bind ocm_output_latency_monitor ocm_output_latency_monitor_asserts chk (.*);
`default_nettype wire

// ===== ocm_host_model.sv
// Host model that drives the strobe register port and the commit inputs.
`default_nettype none
module ocm_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] regRdData,
  output var  logic       regWrEn,
  output var  logic       regRdEn,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWrData,
  output var  logic       frameDelayCommit,
  output var  logic       frameDelayBit16
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle values at time zero; commit starts high as after reset.
  initial begin
    {regWrEn, regRdEn, frameDelayBit16, regAddr, regWrData} = '0;
    frameDelayCommit = 1'b1;
  end
  // Released address and data are inverted so stale values never look valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  // Read data is taken just after the edge that samples the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    #1 d = regRdData;
  endtask
  task automatic fine_wr(input logic [14:0] v);
    wr(ocm_pkg::ADDR_FINE_HIGH, {1'b0, v[14:8]});
    wr(ocm_pkg::ADDR_FINE_LOW, v[7:0]);
  endtask
  task automatic skew_wr(input logic [16:0] v);
    @(posedge ref_clk);
    frameDelayCommit <= 1'b0;
    frameDelayBit16 <= v[16];
    wr(ocm_pkg::ADDR_SKEW_MID, v[15:8]);
    wr(ocm_pkg::ADDR_SKEW_LOW, v[7:0]);
  endtask
  task automatic commit_skew;
    @(posedge ref_clk);
    frameDelayCommit <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== ocm_output_latency_monitor_test.sv
// Self-checking bench for the latency and monitor register bank.
`default_nettype none
module ocm_output_latency_monitor_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIM [4] = '{8, 16, 24, 32};
  localparam logic [7:0] ADR [9] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h00, 8'h15};
  localparam logic [7:0] RST [9] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h2c, 8'h3c, 8'h00, 8'h00};
  localparam logic [7:0] PINS [3] = '{8'h3f, 8'h20, 8'h00};
  logic        ref_clk, rstn, regWrEn, regRdEn, frameDelayCommit, frameDelayBit16, lockLoss;
  logic        phaseStepPinSelect, phaseIncPin, phaseDecPin, phaseSlip, interruptStatus;
  logic        alarmPinOut, alarmPinOe, lockLossPinOut, lockLossPinOe;
  logic [7:0]  regAddr, regWrData, regRdData, coarsePhaseApplied, rdv;
  logic [2:0]  feedbackHighSpeedDivider, faultPinOut, faultPinOe;
  logic [3:0]  offsetDetectInputEnable, offsetRaw, inputValid, offsetDetectEnable;
  logic [3:0]  frequencyOffsetAlarm, inputAlarm;
  logic [1:0]  offsetDetectThreshold;
  logic [16:0] frameSyncDelay;
  logic [14:0] fineLatencyValue;
  int          badCount = 0;
  int          checks = 0;
  ocm_host_model host (.*);
  ocm_output_latency_monitor #(.CLEAR_DELAY0(LIM[0]), .CLEAR_DELAY1(LIM[1]),
    .CLEAR_DELAY2(LIM[2]), .CLEAR_DELAY3(LIM[3]), .ONESHOT_BASE(128), .RAMP_STEP(4)) uut (.*);
  // Compare one value and count it.
  task automatic check(input string n, input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Wait edges, then step past them so registered outputs have settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // The sequence needs about 600 cycles; a hang is cut off well beyond that.
  initial begin
    repeat (20000) @(posedge ref_clk);
    badCount++;
    summarize();
  end
  // Main sequence of register accesses and port checks.
  initial begin
    rstn = 1'b0;
    {phaseStepPinSelect, phaseIncPin, phaseDecPin, phaseSlip, interruptStatus} = 5'h00;
    feedbackHighSpeedDivider = 3'h1;
    offsetDetectInputEnable = 4'h5;
    offsetRaw = 4'h0;
    inputValid = 4'hf;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (ADR[i]) begin
      host.rd(ADR[i], rdv);
      check("reset value", rdv, RST[i]);
    end
    host.wr(8'h14, 8'hff);
    host.rd(8'h14, rdv);
    check("routing", rdv, 8'h3f);
    $display("test registers done");
    interruptStatus <= 1'b1;
    foreach (PINS[i]) begin
      host.wr(8'h14, PINS[i]);
      cyc(2);
      check("pins", {alarmPinOe, alarmPinOut, faultPinOe, lockLossPinOe}, PINS[i]);
    end
    inputValid <= 4'ha;
    phaseSlip <= 1'b1;
    host.wr(8'h14, 8'h1e);
    phaseSlip <= 1'b0;
    cyc(2);
    check("fault pins", {faultPinOut, faultPinOe, lockLossPinOut, alarmPinOe}, 8'hbe);
    inputValid <= 4'hf;
    $display("test pins done");
    host.fine_wr(15'h1255);
    cyc(2);
    check("fine hold", fineLatencyValue, 15'h0000);
    host.wr(8'h11, 8'h92);
    cyc(2);
    check("fine copy", fineLatencyValue, 15'h1255);
    host.skew_wr(17'h1abcd);
    cyc(2);
    check("skew hold", frameSyncDelay, 17'h00000);
    host.commit_skew();
    cyc(2);
    check("skew copy", frameSyncDelay, 17'h1abcd);
    $display("test latency done");
    host.wr(8'h10, 8'h03);
    cyc(30);
    check("coarse up", coarsePhaseApplied, 8'h03);
    phaseIncPin <= 1'b1;
    cyc(6);
    check("pins ignored", coarsePhaseApplied, 8'h03);
    phaseIncPin <= 1'b0;
    host.wr(8'h10, 8'hfe);
    cyc(1);
    check("ramp gradual", coarsePhaseApplied == 8'hfe, 1'b0);
    cyc(40);
    check("coarse down", coarsePhaseApplied, 8'hfe);
    phaseStepPinSelect <= 1'b1;
    phaseIncPin <= 1'b1;
    cyc(6);
    check("pin step up", coarsePhaseApplied, 8'hff);
    phaseIncPin <= 1'b0;
    phaseDecPin <= 1'b1;
    cyc(6);
    check("pin step down", coarsePhaseApplied, 8'hfe);
    phaseDecPin <= 1'b0;
    phaseStepPinSelect <= 1'b0;
    feedbackHighSpeedDivider <= 3'h0;
    host.wr(8'h10, 8'h05);
    cyc(40);
    check("divider off", coarsePhaseApplied, 8'hfe);
    $display("test coarse done");
    offsetRaw <= 4'hf;
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h13, {1'b1, i[1:0], i[1:0], 3'h0});
      inputValid <= 4'h0;
      cyc(2);
      check("offset cfg", {offsetDetectThreshold, frequencyOffsetAlarm}, {i[1:0], 4'h5});
      inputValid <= 4'hf;
      cyc(LIM[i] - 1);
      check("alarm held", inputAlarm, 4'hf);
      cyc(1);
      check("alarm clear", inputAlarm, 4'h0);
    end
    host.wr(8'h13, 8'h60);
    cyc(3);
    check("offset off", {offsetDetectEnable, frequencyOffsetAlarm}, 8'h00);
    $display("test monitor done");
    for (int i = 0; i < 8; i++) begin
      host.wr(8'h13, {5'h00, i[2:0]});
      phaseSlip <= 1'b1;
      cyc(1);
      phaseSlip <= 1'b0;
      check("lock start", lockLoss, 1'b1);
      cyc((128 >> i) - 1);
      check("lock held", lockLoss, 1'b1);
      cyc(1);
      check("lock end", lockLoss, 1'b0);
    end
    $display("test one-shot done");
    summarize();
  end
endmodule
`default_nettype wire
